// ===== src/rfid_tx_frame_setup_fifo.sv
// Purpose: Transmit framing setup registers, data FIFO and bit serialiser.
// Assumes: Register strobes and command strobe are synchronous to clk.
// Notes: Low enable holds the whole block in reset.
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R1] CRC select bit picks CRC-16 or CRC-5
// [R2] Query command always requests calibration period
// [R3] Force bit adds calibration to plain transmits
// [R4] Session bits go into the query frame
// [R5] Twelve-bit full byte count over two registers
// [R6] Three bits give final partial byte length
// [R7] FIFO port fills and drains cyclically
// [R8] Pushing into full FIFO sets overflow flag
// [R9] Unread count shown, all ones after empty read
// [R10] Status bit 7 high while transmitting
// [R11] Reserved bits ignored and read as zero
module rfid_tx_frame_setup_fifo (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic tx_bit,
  output logic tx_bit_valid,
  input wire logic tx_bit_ready,
  output logic tx_frame_start,
  output logic tx_calib_insert,
  output logic tx_frame_done,
  output logic fifo_wr_ready
);
  import rtf_pkg::*;

  // ****************************************
  // Reset and register storage
  // ****************************************
  logic rst_int;
  logic [7:0] setting_r;
  logic [7:0] len_up_r;
  logic [7:0] len_lo_r;
  logic [7:0] query_a_r;
  logic [7:0] query_b_r;
  logic ovfl_r;
  logic empty_rd_r;
  logic [7:0] rdata_r;
  logic [4:0] fifo_count;

  // Disabled device behaves exactly like one under reset
  assign rst_int = rst | ~enable;

  // ****************************************
  // Decoded fields
  // ****************************************
  logic short_crc_select;
  logic force_calibration_insert;
  logic session_select_hi;
  logic session_select_lo;
  logic [11:0] tx_full_byte_count;
  logic [2:0] partial_byte_bits;
  logic [7:0] fifo_port_data;
  logic [4:0] fifo_unread_count;

  assign short_crc_select = setting_r[SET_SHORT_CRC_BIT];
  assign force_calibration_insert = setting_r[SET_FORCE_CAL_BIT];
  assign session_select_hi = setting_r[SET_SESSION_HI_BIT];
  assign session_select_lo = setting_r[SET_SESSION_LO_BIT];
  assign tx_full_byte_count = {len_up_r, len_lo_r[7:LEN_LO_NIBBLE_LSB]}; // see [R5]
  assign partial_byte_bits = len_lo_r[PARTIAL_MSB:PARTIAL_LSB]; // see [R6]

  // ****************************************
  // FIFO and its handshakes
  // ****************************************
  rtf_stream_if #(.W(FIFO_W)) push_if ();
  rtf_stream_if #(.W(FIFO_W)) pop_if ();

  rtf_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .CW(5)
  ) u_fifo (
    .clk(clk),
    .rst(rst_int),
    .in_if(push_if),
    .out_if(pop_if),
    .count(fifo_count)
  );

  rtf_state_type state_r;
  logic busy;
  logic wr_fifo;
  logic rd_fifo;
  logic host_pop;
  logic fsm_pop;
  logic fsm_take;
  logic [4:0] bits_left_r;
  logic [11:0] bytes_left_r;
  logic partial_pend_r;

  assign busy = (state_r != ST_IDLE);
  assign wr_fifo = reg_wr & (reg_addr == ADDR_FIFO_PORT);
  assign rd_fifo = reg_rd & (reg_addr == ADDR_FIFO_PORT);
  assign fifo_port_data = pop_if.data;
  // Host reads drain the FIFO only while no frame owns it
  assign host_pop = rd_fifo & ~busy; // see [R7]
  assign fsm_pop = (state_r == ST_DATA) && (bits_left_r == 5'h00) &&
                   ((bytes_left_r != 12'h000) || partial_pend_r);
  assign fsm_take = fsm_pop & pop_if.valid;
  assign push_if.valid = wr_fifo; // see [R7]
  assign push_if.data = reg_wdata;
  assign pop_if.ready = host_pop | fsm_pop;
  assign fifo_wr_ready = push_if.ready;
  // An empty read is remembered so the count field can flag it
  assign fifo_unread_count = empty_rd_r ? FB_EMPTY_READ : fifo_count; // see [R9]

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      setting_r <= REG_RESET;
      len_up_r <= REG_RESET;
      len_lo_r <= REG_RESET;
      query_a_r <= REG_RESET;
      query_b_r <= REG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_TX_SETTING: begin
          setting_r <= reg_wdata & SETTING_MASK; // see [R11]
        end
        ADDR_TX_LEN_UP: begin
          len_up_r <= reg_wdata; // see [R5]
        end
        ADDR_TX_LEN_LO: begin
          len_lo_r <= reg_wdata & LEN_LO_MASK; // see [R11]
        end
        ADDR_QUERY_A: begin
          query_a_r <= reg_wdata & QUERY_A_MASK;
        end
        ADDR_QUERY_B: begin
          query_b_r <= reg_wdata & QUERY_B_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Sticky FIFO flags
  // ****************************************
  // Overflow clears on a status read; a new overflow in that cycle wins
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      ovfl_r <= 1'b0;
    end else if (wr_fifo && !push_if.ready) begin
      ovfl_r <= 1'b1; // see [R8]
    end else if (reg_rd && reg_addr == ADDR_FIFO_STATUS) begin
      ovfl_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      empty_rd_r <= 1'b0;
    end else if (host_pop && !pop_if.valid) begin
      empty_rd_r <= 1'b1; // see [R9]
    end else if (wr_fifo && push_if.ready) begin
      empty_rd_r <= 1'b0;
    end
  end

  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_FIFO_STATUS: begin
          rdata_r <= {busy, 1'b0, ovfl_r, fifo_unread_count}; // see [R10]
        end
        ADDR_TX_SETTING: begin
          rdata_r <= setting_r; // see [R11]
        end
        ADDR_TX_LEN_UP: begin
          rdata_r <= len_up_r;
        end
        ADDR_TX_LEN_LO: begin
          rdata_r <= len_lo_r; // see [R11]
        end
        ADDR_QUERY_A: begin
          rdata_r <= query_a_r;
        end
        ADDR_QUERY_B: begin
          rdata_r <= query_b_r;
        end
        ADDR_FIFO_PORT: begin
          rdata_r <= (host_pop && pop_if.valid) ? fifo_port_data : 8'h00; // see [R7]
        end
        default: begin
          rdata_r <= 8'h00;
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Frame sequencer
  // ****************************************
  logic crc_on_r;
  logic crc_short_r;
  logic calib_r;
  logic start_r;
  logic done_r;
  logic [16:0] sh_r;
  logic [15:0] crc16;
  logic [4:0] crc5;
  logic cmd_take;
  logic bit_go;

  // Commands arriving mid-frame are dropped, never queued
  assign cmd_take = cmd_valid & (state_r == ST_IDLE) &
                    ((cmd_code == CMD_QUERY) || (cmd_code == CMD_TX_CRC) ||
                     (cmd_code == CMD_TX_NOCRC));
  assign tx_bit_valid = ((state_r == ST_DATA) || (state_r == ST_CRC)) &&
                        (bits_left_r != 5'h00);
  assign bit_go = tx_bit_valid & tx_bit_ready;
  assign tx_bit = sh_r[16];
  assign tx_frame_start = start_r;
  assign tx_calib_insert = calib_r;
  assign tx_frame_done = done_r;

  rtf_crc u_crc (
    .clk(clk),
    .rst(rst_int),
    .init(start_r),
    .shift(bit_go && state_r == ST_DATA),
    .bit_in(sh_r[16]),
    .crc16(crc16),
    .crc5(crc5)
  );

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_take) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          if (bits_left_r == 5'h00 && bytes_left_r == 12'h000 && !partial_pend_r) begin
            state_r <= crc_on_r ? ST_CRC : ST_DONE;
          end
        end
        ST_CRC: begin
          if (bit_go && bits_left_r == 5'h01) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Frame options are frozen at command time
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      crc_on_r <= 1'b0;
      crc_short_r <= 1'b0;
      calib_r <= 1'b0;
    end else if (cmd_take) begin
      if (cmd_code == CMD_QUERY) begin
        crc_on_r <= 1'b1;
        crc_short_r <= 1'b1;
        calib_r <= 1'b1; // see [R2]
      end else begin
        crc_on_r <= (cmd_code == CMD_TX_CRC);
        crc_short_r <= short_crc_select; // see [R1]
        calib_r <= force_calibration_insert; // see [R3]
      end
    end
  end

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      start_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      start_r <= cmd_take;
      done_r <= (state_r == ST_DONE);
    end
  end

  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      bytes_left_r <= 12'h000;
      partial_pend_r <= 1'b0;
    end else if (cmd_take) begin
      if (cmd_code == CMD_QUERY) begin
        bytes_left_r <= 12'h000;
        partial_pend_r <= 1'b0;
      end else begin
        bytes_left_r <= tx_full_byte_count; // see [R5]
        partial_pend_r <= (partial_byte_bits != 3'h0); // see [R6]
      end
    end else if (fsm_take) begin
      if (bytes_left_r != 12'h000) begin
        bytes_left_r <= bytes_left_r - 12'h001;
      end else begin
        partial_pend_r <= 1'b0;
      end
    end
  end

  // One shift register carries payload bits and then the CRC, MSB first
  always_ff @(posedge clk or posedge rst_int) begin
    if (rst_int) begin
      sh_r <= 17'h00000;
      bits_left_r <= 5'h00;
    end else if (cmd_take) begin
      if (cmd_code == CMD_QUERY) begin
        sh_r <= {QUERY_CODE, query_a_r[5:0], session_select_hi,
                 session_select_lo, query_b_r[4:0]}; // see [R4]
        bits_left_r <= QUERY_BITS;
      end else begin
        sh_r <= 17'h00000;
        bits_left_r <= 5'h00;
      end
    end else if (fsm_take) begin
      sh_r <= {pop_if.data, 9'h000};
      bits_left_r <= (bytes_left_r != 12'h000) ? BYTE_BITS :
                     {2'b00, partial_byte_bits}; // see [R6]
    end else if (state_r == ST_DATA && bits_left_r == 5'h00 &&
                 bytes_left_r == 12'h000 && !partial_pend_r && crc_on_r) begin
      if (crc_short_r) begin
        sh_r <= {crc5, 12'h000}; // see [R1]
        bits_left_r <= CRC5_LEN;
      end else begin
        sh_r <= {~crc16, 1'b0}; // see [R1]
        bits_left_r <= CRC16_LEN;
      end
    end else if (bit_go) begin
      sh_r <= {sh_r[15:0], 1'b0};
      bits_left_r <= bits_left_r - 5'h01;
    end
  end
endmodule : rfid_tx_frame_setup_fifo
`default_nettype wire

// ===== src/rtf_crc.sv
// Purpose: Serial CRC-16 and CRC-5 generators run side by side.
// Assumes: Bits enter MSB first.
// Notes: Caller picks the result and complements CRC-16.
`timescale 1ns/100ps
`default_nettype none
module rtf_crc
  import rtf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic init,
  input wire logic shift,
  input wire logic bit_in,
  output logic [15:0] crc16,
  output logic [4:0] crc5
);
  logic fb16;
  logic fb5;

  assign fb16 = bit_in ^ crc16[15];
  assign fb5 = bit_in ^ crc5[4];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc16 <= CRC16_PRESET;
      crc5 <= CRC5_PRESET;
    end else if (init) begin
      crc16 <= CRC16_PRESET;
      crc5 <= CRC5_PRESET;
    end else if (shift) begin
      crc16 <= {crc16[14:0], 1'b0} ^ (fb16 ? CRC16_POLY : 16'h0000);
      crc5 <= {crc5[3:0], 1'b0} ^ (fb5 ? CRC5_POLY : 5'h00);
    end
  end
endmodule : rtf_crc
`default_nettype wire

// ===== src/rtf_fifo.sv
// Purpose: Cyclic flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH of at least two.
// Notes: Head data is read straight from storage.
`timescale 1ns/100ps
`default_nettype none
module rtf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 24,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  rtf_stream_if.snk in_if,
  rtf_stream_if.src out_if,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  assign in_if.ready = (count_r != CW'(DEPTH));
  assign out_if.valid = (count_r != '0);
  assign out_if.data = mem_r[rd_ptr_r];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_if.valid & out_if.ready;
  assign count = count_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_if.data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end
endmodule : rtf_fifo
`default_nettype wire

// ===== src/rtf_pkg.sv
// Purpose: Shared constants and types of the transmit framing setup block.
// Assumes: 8-bit register port, 6-bit register address.
// Notes: Offsets 30h, 31h hold extra query fields.
package rtf_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] ADDR_FIFO_STATUS = 6'h39;
  localparam logic [5:0] ADDR_TX_SETTING = 6'h3C;
  localparam logic [5:0] ADDR_TX_LEN_UP = 6'h3D;
  localparam logic [5:0] ADDR_TX_LEN_LO = 6'h3E;
  localparam logic [5:0] ADDR_FIFO_PORT = 6'h3F;
  localparam logic [5:0] ADDR_QUERY_A = 6'h30;
  localparam logic [5:0] ADDR_QUERY_B = 6'h31;
  // ****************************************
  // Field positions, masks, reset values
  // ****************************************
  localparam int SET_SHORT_CRC_BIT = 3;
  localparam int SET_FORCE_CAL_BIT = 2;
  localparam int SET_SESSION_HI_BIT = 1;
  localparam int SET_SESSION_LO_BIT = 0;
  localparam int LEN_LO_NIBBLE_LSB = 4;
  localparam int PARTIAL_MSB = 3;
  localparam int PARTIAL_LSB = 1;
  localparam logic [7:0] SETTING_MASK = 8'h0F;
  localparam logic [7:0] LEN_LO_MASK = 8'hFE;
  localparam logic [7:0] QUERY_A_MASK = 8'h3F;
  localparam logic [7:0] QUERY_B_MASK = 8'h1F;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************************************
  // FIFO
  // ****************************************
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 24;
  localparam logic [4:0] FB_EMPTY_READ = 5'h1F;
  // ****************************************
  // Commands and framing
  // ****************************************
  localparam logic [7:0] CMD_TX_CRC = 8'h90;
  localparam logic [7:0] CMD_TX_NOCRC = 8'h91;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [3:0] QUERY_CODE = 4'h8;
  localparam logic [4:0] QUERY_BITS = 5'h11;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CRC16_LEN = 5'h10;
  localparam logic [4:0] CRC5_LEN = 5'h05;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_PRESET = 16'hFFFF;
  localparam logic [4:0] CRC5_POLY = 5'h09;
  localparam logic [4:0] CRC5_PRESET = 5'h09;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_CRC = 5'b01000,
    ST_DONE = 5'b10000
  } rtf_state_type;
endpackage : rtf_pkg

// ===== src/rtf_stream_if.sv
// Purpose: Valid/ready byte stream between the block's own modules.
// Assumes: Transfer when valid and ready are both high at a rising edge.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface rtf_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : rtf_stream_if
`default_nettype wire

// ===== test/rtf_checker.sv
// Purpose: Port-level assertions for the transmit framing block.
// Assumes: One clock; rst or low enable clears the block.
// Notes: Helper flops track busy state, last command and force bit.
`timescale 1ns/100ps
`default_nettype none
module rtf_checker
  import rtf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_ready,
  input wire logic tx_frame_start,
  input wire logic tx_calib_insert,
  input wire logic tx_frame_done,
  input wire logic fifo_wr_ready
);
  logic busy_r;
  logic force_r;
  logic [7:0] code_r;
  logic [7:0] bits_r;
  // ********
  // Helper state
  // ********
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !enable) begin
      busy_r <= 1'b0;
      code_r <= 8'h00;
    end else begin
      if (tx_frame_start) busy_r <= 1'b1;
      else if (tx_frame_done) busy_r <= 1'b0;
      if (cmd_valid && !busy_r && !tx_frame_start) code_r <= cmd_code;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !enable) begin
      force_r <= 1'b0;
      bits_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == ADDR_TX_SETTING) force_r <= reg_wdata[SET_FORCE_CAL_BIT];
      if (tx_frame_start) bits_r <= 8'h00;
      else if (tx_bit_valid && tx_bit_ready) bits_r <= bits_r + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !enable);
  // A command counts only while the sequencer is idle
  sequence s_cmd_ok;
    cmd_valid && !busy_r && !tx_frame_start &&
      (cmd_code == CMD_TX_CRC || cmd_code == CMD_TX_NOCRC || cmd_code == CMD_QUERY);
  endsequence
  sequence s_query_start;
    cmd_valid && !busy_r && !tx_frame_start && cmd_code == CMD_QUERY ##1 tx_frame_start;
  endsequence
  a_cmd_starts: assert property (s_cmd_ok |=> tx_frame_start)
    else $error("frame start missing");
  a_start_pulse: assert property (tx_frame_start |=> !tx_frame_start)
    else $error("frame start too long");
  a_start_quiet: assert property (tx_frame_start |-> !tx_bit_valid && !busy_r)
    else $error("bit offered at frame start");
  a_query_calib: assert property (s_query_start |-> tx_calib_insert)
    else $error("query without calibration");
  a_force_calib: assert property (tx_frame_start && code_r != CMD_QUERY |->
    tx_calib_insert == force_r)
    else $error("calibration differs from force bit");
  a_query_length: assert property (tx_frame_done && code_r == CMD_QUERY |->
    bits_r == 8'h16)
    else $error("query frame length wrong");
  a_bit_hold: assert property (tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit))
    else $error("bit dropped before ready");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == REG_RESET)
    else $error("read data outside answer cycle");
endmodule : rtf_checker
bind rfid_tx_frame_setup_fifo rtf_checker chk (.clk(clk), .rst(rst), .enable(enable),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_bit(tx_bit),
  .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .tx_frame_start(tx_frame_start),
  .tx_calib_insert(tx_calib_insert), .tx_frame_done(tx_frame_done),
  .fifo_wr_ready(fifo_wr_ready));
`default_nettype wire

// ===== test/rtf_modulator_model.sv
// Purpose: Modulator stand-in that takes serial bits at the far side.
// Assumes: A bit moves when valid and ready are high at a rising edge.
// Notes: Slow mode stalls at random to stretch frames.
`timescale 1ns/100ps
`default_nettype none
module rtf_modulator_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  output logic tx_bit_ready
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_bit_ready <= 1'b0;
    end else begin
      tx_bit_ready <= !slow || 1'($urandom_range(1));
    end
  end
endmodule : rtf_modulator_model
`default_nettype wire

// ===== test/tb_rfid_tx_frame_setup_fifo.sv
// Purpose: Self-checking bench for the transmit framing block.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes: Drivers queue expectations; one monitor compares them.
`timescale 1ns/100ps
`default_nettype none
module tb_rfid_tx_frame_setup_fifo;
  import rtf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic slow = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_rdata;
  logic tx_bit, tx_bit_valid, tx_bit_ready, tx_frame_start, tx_calib_insert, tx_frame_done;
  logic fifo_wr_ready;
  logic [15:0] e;
  logic [15:0] c16;
  logic [4:0] c5;
  logic [15:0] exp_rd[$];
  logic exp_bit[$];
  logic exp_cal[$];
  logic [7:0] fq[$];
  int err_count = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  rfid_tx_frame_setup_fifo dut (.clk(clk), .rst(rst), .enable(enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_bit_ready(tx_bit_ready), .tx_frame_start(tx_frame_start),
    .tx_calib_insert(tx_calib_insert), .tx_frame_done(tx_frame_done),
    .fifo_wr_ready(fifo_wr_ready));
  rtf_modulator_model partner (.clk(clk), .rst(rst), .slow(slow), .tx_bit_ready(tx_bit_ready));
  // ********
  // Shared tasks and monitor
  // ********
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Mask lets a busy-time status read ignore the moving byte count
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] x);
    exp_rd.push_back({m, x});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pushbit(input logic b);
    exp_bit.push_back(b);
    c16 = (c16 << 1) ^ ((c16[15] ^ b) ? CRC16_POLY : 16'h0000);
    c5 = (c5 << 1) ^ ((c5[4] ^ b) ? CRC5_POLY : 5'h00);
  endtask : pushbit
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      e = exp_rd.pop_front();
      chk("reg_rdata", e[7:0], reg_rdata & e[15:8]);
    end
    if (tx_bit_valid && tx_bit_ready) chk("tx_bit", {7'h00, exp_bit.pop_front()}, {7'h00, tx_bit});
    if (tx_frame_start) chk("calib", {7'h00, exp_cal.pop_front()}, {7'h00, tx_calib_insert});
  end
  task automatic frame(input logic [7:0] cmd, input logic [3:0] set, input logic sl);
    int n;
    int pb;
    logic [7:0] d;
    logic [16:0] qf;
    logic [15:0] f16;
    logic seen;
    n = $urandom_range(3, 1);
    pb = $urandom_range(7);
    qf = {QUERY_CODE, 6'($urandom), set[1:0], 5'($urandom)};
    c16 = CRC16_PRESET;
    c5 = CRC5_PRESET;
    seen = 1'b0;
    slow <= sl;
    wr(ADDR_TX_SETTING, {4'h0, set});
    wr(ADDR_TX_LEN_UP, n[11:4]);
    wr(ADDR_TX_LEN_LO, {n[3:0], pb[2:0], 1'b0});
    wr(ADDR_QUERY_A, {2'b00, qf[12:7]});
    wr(ADDR_QUERY_B, {3'b000, qf[4:0]});
    if (cmd == CMD_QUERY) begin
      for (int i = 16; i >= 0; i--) pushbit(qf[i]);
    end else begin
      for (int k = 0; k <= n; k++) begin
        d = 8'($urandom);
        if (k < n || pb > 0) wr(ADDR_FIFO_PORT, d);
        for (int i = 7; i >= 0; i--) if (k < n || 7 - i < pb) pushbit(d[i]);
      end
    end
    f16 = ~c16;
    if (cmd == CMD_QUERY || (cmd == CMD_TX_CRC && set[SET_SHORT_CRC_BIT])) begin
      for (int i = 4; i >= 0; i--) exp_bit.push_back(c5[i]);
    end else if (cmd == CMD_TX_CRC) begin
      for (int i = 15; i >= 0; i--) exp_bit.push_back(f16[i]);
    end
    exp_cal.push_back(cmd == CMD_QUERY || set[SET_FORCE_CAL_BIT]);
    @(posedge clk);
    cmd_code <= cmd;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (sl) begin
      rd(ADDR_FIFO_STATUS, 8'h80, 8'h80);
      // Repeat while busy: must be dropped, else extra bits and a busy status follow
      @(posedge clk);
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
    end
    for (int t = 0; t < 3000 && !seen; t++) begin
      @(negedge clk);
      seen = tx_frame_done;
    end
    chk("frame_done", 8'h01, {7'h00, seen});
    chk("bits_left", 8'h00, 8'(exp_bit.size()));
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'h00);
    $display("test frame %h done", cmd);
  endtask : frame
  initial begin
    #(50 * 40000);
    err_count++;
    $display("test watchdog expired");
    tally_and_finish();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] m;
    void'($urandom(32'hAF9A802D));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) rd(ADDR_TX_SETTING + 6'(a), 8'hFF, REG_RESET);
    rd(6'h00, 8'hFF, 8'h00);
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'h00);
    $display("test reset done");
    for (int a = 0; a < 3; a++) begin
      m = (a == 0) ? SETTING_MASK : (a == 1) ? 8'hFF : LEN_LO_MASK;
      v = 8'($urandom) & m;
      wr(ADDR_TX_SETTING + 6'(a), v);
      rd(ADDR_TX_SETTING + 6'(a), 8'hFF, v);
    end
    $display("test regs done");
    for (int k = 0; k <= FIFO_DEPTH; k++) begin
      v = 8'($urandom);
      if (k < FIFO_DEPTH) fq.push_back(v);
      wr(ADDR_FIFO_PORT, v);
    end
    chk("fifo_wr_ready", 8'h00, {7'h00, fifo_wr_ready});
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'h20 | 8'(FIFO_DEPTH));
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'(FIFO_DEPTH));
    while (fq.size() > 0) rd(ADDR_FIFO_PORT, 8'hFF, fq.pop_front());
    chk("fifo_wr_ready", 8'h01, {7'h00, fifo_wr_ready});
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'h00);
    rd(ADDR_FIFO_PORT, 8'hFF, 8'h00);
    rd(ADDR_FIFO_STATUS, 8'hFF, {3'b000, FB_EMPTY_READ});
    $display("test fifo done");
    @(posedge clk);
    enable <= 1'b0;
    @(posedge clk);
    enable <= 1'b1;
    rd(ADDR_TX_SETTING, 8'hFF, REG_RESET);
    rd(ADDR_FIFO_STATUS, 8'hFF, 8'h00);
    $display("test enable done");
    frame(CMD_TX_CRC, 4'h0, 1'b0);
    frame(CMD_TX_CRC, 4'hC, 1'b1);
    frame(CMD_TX_NOCRC, 4'h4, 1'b1);
    frame(CMD_TX_NOCRC, 4'h8, 1'b0);
    for (int s = 0; s < 4; s++) frame(CMD_QUERY, 4'(s), s[0]);
    tally_and_finish();
  end
endmodule : tb_rfid_tx_frame_setup_fifo
`default_nettype wire
